/* File: hw/aac_engine.sv */
/*
 * Access-control action and count engine for one switch port.
 * Holds a 16-entry action/count table written by software, applies the
 * action of the matched entry to priority, PCP and forwarding map, and
 * runs per-entry count-mode counters that raise a port interrupt.
 * Assumes match results and lookup map arrive synchronous to clk_i,
 * one packet per valid cycle, with a single winning entry index.
 */
// Operation
// - Mode 00 keeps QoS priority
// - 01 higher, 10 lower, 11 always override
// - Remark enable replaces PCP with remark value
// - Map 00 passes, 01 ORs mask
// - Map 10 ANDs mask with lookup map
// - Map 11 replaces lookup map with mask
// - Mask bit 0 is port 1; 1 forwards
// - Time unit 0 microseconds, 1 milliseconds
// - Algorithm 0 counts down, interrupts on expiry
// - Algorithm 1 counts packets, interrupts, then resets
// - Table of 16 entries, three fields each
// - Count mode pairs match and action fields
// - Only count mode entries raise interrupts
// - Count mode tracks one MAC/EtherType kind
// - Per-port status and mask feed aggregate
// - Count value overlays the action fields
// - Match mode 00 disables the entry
`timescale 1ns/10ps
`default_nettype none

module aac_engine #(
  parameter int PORTS = 7,           // Switch ports in the forward mask
  parameter int ENTRIES = aac_pkg::ENTRIES,
  parameter int MS_UNITS = aac_pkg::MS_PER_US  // Microseconds per ms tick
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Table write port
  input wire logic wr_en_i,
  input wire logic [aac_pkg::IDX_W-1:0] wr_idx_i,
  input wire logic [1:0] wr_match_mode_i,
  input wire logic [1:0] wr_match_select_i,
  input wire logic [aac_pkg::ACT_FIXED_W+PORTS-1:0] wr_action_i,
  input wire logic [31:0] wr_process_i,
  // Packet from match logic and address lookup
  input wire logic pkt_valid_i,
  input wire logic pkt_hit_i,
  input wire logic [aac_pkg::IDX_W-1:0] pkt_idx_i,
  input wire logic [aac_pkg::PRI_W-1:0] qos_pri_i,
  input wire logic [aac_pkg::PRI_W-1:0] pcp_i,
  input wire logic [PORTS-1:0] lookup_map_i,
  // Result to queueing and egress
  output logic res_valid_o,
  output logic [aac_pkg::PRI_W-1:0] res_pri_o,
  output logic [aac_pkg::PRI_W-1:0] res_pcp_o,
  output logic [PORTS-1:0] res_map_o,
  output logic [31:0] res_process_o,
  // Interrupt status and mask
  input wire logic [ENTRIES-1:0] int_clear_i,
  input wire logic int_mask_i,
  output logic [ENTRIES-1:0] int_status_o,
  output logic port_int_o
);
  localparam int AW = aac_pkg::ACT_FIXED_W + PORTS;
  localparam int CW = aac_pkg::CNT_W;
  localparam int IDX_W = aac_pkg::IDX_W;

  // Elaboration check: table index and mask width must fit
  if (ENTRIES != aac_pkg::ENTRIES || PORTS < 1 || MS_UNITS < 1) begin : g_bad
    $error("aac_engine: unsupported parameter values");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Count mode is match mode L2 with match select count
  function automatic logic is_count(input logic [1:0] mm, input logic [1:0] ms);
    return (mm == aac_pkg::MATCH_MODE_L2) && (ms == aac_pkg::MATCH_SEL_COUNT);
  endfunction : is_count

  // ****************************************************************
  // Table storage
  // ****************************************************************
  logic [1:0] mmode_q [ENTRIES];     // Match mode per entry
  logic [1:0] msel_q [ENTRIES];      // Match select per entry
  logic [AW-1:0] act_q [ENTRIES];    // Action field per entry
  logic [31:0] proc_q [ENTRIES];     // Process field per entry

  // Table is a plain register array; writes go straight in
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        mmode_q[i] <= aac_pkg::MATCH_MODE_OFF;
        msel_q[i] <= 2'h0;
        act_q[i] <= '0;
        proc_q[i] <= 32'h0;
      end
    end else if (wr_en_i) begin
      mmode_q[wr_idx_i] <= wr_match_mode_i;
      msel_q[wr_idx_i] <= wr_match_select_i;
      act_q[wr_idx_i] <= wr_action_i;
      proc_q[wr_idx_i] <= wr_process_i;
    end
  end

  // ****************************************************************
  // Action path
  // ****************************************************************
  logic [AW-1:0] act;
  logic hit_ok;
  logic hit_count;
  logic res_valid_d, res_valid_q;
  logic [aac_pkg::PRI_W-1:0] res_pri_d, res_pri_q, res_pcp_d, res_pcp_q;
  logic [PORTS-1:0] res_map_d, res_map_q, fwd;
  logic [31:0] res_proc_d, res_proc_q;

  // Compute the result of one packet
  always_comb begin
    logic [1:0] pm;
    logic [2:0] pri;
    pm = 2'h0;
    pri = 3'h0;
    act = act_q[pkt_idx_i];
    hit_ok = pkt_valid_i && pkt_hit_i && (mmode_q[pkt_idx_i] != aac_pkg::MATCH_MODE_OFF);
    hit_count = hit_ok && is_count(mmode_q[pkt_idx_i], msel_q[pkt_idx_i]);
    fwd = act[aac_pkg::F_FWD_LSB +: PORTS];
    pm = act[aac_pkg::F_PM_LSB +: 2];
    pri = act[aac_pkg::F_PRI_LSB +: 3];
    res_valid_d = pkt_valid_i;
    res_pri_d = qos_pri_i;
    res_pcp_d = pcp_i;
    res_map_d = lookup_map_i;
    res_proc_d = hit_ok ? proc_q[pkt_idx_i] : 32'h0;
    // Count-mode entries reuse these bits as the count, so no action
    if (hit_ok && !hit_count) begin
      case (pm)
        aac_pkg::PRI_IF_HIGHER: if (pri > qos_pri_i) res_pri_d = pri;
        aac_pkg::PRI_IF_LOWER: if (pri < qos_pri_i) res_pri_d = pri;
        aac_pkg::PRI_ALWAYS: res_pri_d = pri;
        default: res_pri_d = qos_pri_i;
      endcase
      if (act[aac_pkg::F_RPE]) begin
        res_pcp_d = act[aac_pkg::F_RPRI_LSB +: 3];
      end
      case (act[aac_pkg::F_MAP_LSB +: 2])
        aac_pkg::MAP_OR: res_map_d = lookup_map_i | fwd;
        aac_pkg::MAP_AND: res_map_d = lookup_map_i & fwd;
        aac_pkg::MAP_REPLACE: res_map_d = fwd;
        default: res_map_d = lookup_map_i;
      endcase
    end
  end

  // Result registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_valid_q <= 1'b0;
      res_pri_q <= 3'h0;
      res_pcp_q <= 3'h0;
      res_map_q <= '0;
      res_proc_q <= 32'h0;
    end else begin
      res_valid_q <= res_valid_d;
      res_pri_q <= res_pri_d;
      res_pcp_q <= res_pcp_d;
      res_map_q <= res_map_d;
      res_proc_q <= res_proc_d;
    end
  end

  assign res_valid_o = res_valid_q;
  assign res_pri_o = res_pri_q;
  assign res_pcp_o = res_pcp_q;
  assign res_map_o = res_map_q;
  assign res_process_o = res_proc_q;

  // ****************************************************************
  // Time base: microsecond and millisecond ticks
  // ****************************************************************
  localparam int PW = $clog2(aac_pkg::US_CYCLES);
  localparam int MW = $clog2(MS_UNITS + 1);
  logic [PW-1:0] us_cnt_d, us_cnt_q;
  logic [MW-1:0] ms_cnt_d, ms_cnt_q;
  logic us_tick, ms_tick;

  // Prescaler from the core clock
  always_comb begin
    us_tick = (us_cnt_q == PW'(aac_pkg::US_CYCLES - 1));
    us_cnt_d = us_tick ? '0 : us_cnt_q + 1'b1;
    ms_tick = us_tick && (ms_cnt_q == MW'(MS_UNITS - 1));
    ms_cnt_d = ms_cnt_q;
    if (us_tick) begin
      ms_cnt_d = ms_tick ? '0 : ms_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      us_cnt_q <= '0;
      ms_cnt_q <= '0;
    end else begin
      us_cnt_q <= us_cnt_d;
      ms_cnt_q <= ms_cnt_d;
    end
  end

  // ****************************************************************
  // Count-mode counters and interrupt status
  // ****************************************************************
  logic [CW-1:0] cnt_d [ENTRIES];
  logic [CW-1:0] cnt_q [ENTRIES];
  logic [ENTRIES-1:0] run_d, run_q;  // Countdown armed
  logic [ENTRIES-1:0] sts_d, sts_q;  // Sticky per-entry status

  // One counter per entry; only count-mode entries can fire
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      logic [CW-1:0] limit;
      logic tick;
      logic hit;
      logic fire;
      limit = act_q[i][aac_pkg::F_COUNT_LSB +: CW];
      tick = act_q[i][aac_pkg::F_TU] ? ms_tick : us_tick;
      hit = hit_count && (pkt_idx_i == IDX_W'(i));
      fire = 1'b0;
      cnt_d[i] = cnt_q[i];
      run_d[i] = run_q[i];
      if (!is_count(mmode_q[i], msel_q[i]) || (wr_en_i && wr_idx_i == IDX_W'(i))) begin
        cnt_d[i] = '0;
        run_d[i] = 1'b0;
      end else if (act_q[i][aac_pkg::F_CA]) begin
        run_d[i] = 1'b0;
        if (hit) begin
          if (cnt_q[i] + 1'b1 >= limit) begin
            fire = 1'b1;
            cnt_d[i] = '0;
          end else begin
            cnt_d[i] = cnt_q[i] + 1'b1;
          end
        end
      end else begin
        if (hit) begin
          cnt_d[i] = limit;
          run_d[i] = 1'b1;
        end else if (run_q[i] && tick) begin
          if (cnt_q[i] <= CW'(1)) begin
            fire = 1'b1;
            run_d[i] = 1'b0;
            cnt_d[i] = '0;
          end else begin
            cnt_d[i] = cnt_q[i] - 1'b1;
          end
        end
      end
      // Set wins over a clear in the same cycle
      sts_d[i] = fire | (sts_q[i] & ~int_clear_i[i]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        cnt_q[i] <= '0;
      end
      run_q <= '0;
      sts_q <= '0;
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
      run_q <= run_d;
      sts_q <= sts_d;
    end
  end

  // Aggregated port interrupt, gated by the port mask (high = masked)
  assign int_status_o = sts_q;
  assign port_int_o = (|sts_q) & ~int_mask_i;
endmodule : aac_engine

`default_nettype wire

/* File: common/aac_pkg.sv */
/*
 * Package for the access-control action and count engine: field codes,
 * entry layout, table size and time-unit counts.
 * Assumes a 200 MHz core clock; nothing else from the surroundings.
 */
package aac_pkg;
  // ****************************************************************
  // Table and field sizes
  // ****************************************************************
  localparam int ENTRIES = 16;       // Table depth
  localparam int IDX_W = 4;          // Entry index width
  localparam int CNT_W = 11;         // Count-mode counter width
  localparam int PRI_W = 3;          // Priority width

  // Match mode and match select codes
  localparam logic [1:0] MATCH_MODE_OFF = 2'h0;
  localparam logic [1:0] MATCH_MODE_L2 = 2'h1;
  localparam logic [1:0] MATCH_SEL_COUNT = 2'h0;

  // Priority override modes
  localparam logic [1:0] PRI_NONE = 2'h0;
  localparam logic [1:0] PRI_IF_HIGHER = 2'h1;
  localparam logic [1:0] PRI_IF_LOWER = 2'h2;
  localparam logic [1:0] PRI_ALWAYS = 2'h3;

  // Forward map modes
  localparam logic [1:0] MAP_PASS = 2'h0;
  localparam logic [1:0] MAP_OR = 2'h1;
  localparam logic [1:0] MAP_AND = 2'h2;
  localparam logic [1:0] MAP_REPLACE = 2'h3;

  // ****************************************************************
  // Action word layout (low bits)
  // ****************************************************************
  localparam int F_MAP_LSB = 0;      // forward_map_mode[1:0]
  localparam int F_RPRI_LSB = 2;     // remark_priority[2:0]
  localparam int F_RPE = 5;          // remark_enable
  localparam int F_PRI_LSB = 6;      // override priority[2:0]
  localparam int F_PM_LSB = 9;       // priority_override_mode[1:0]
  localparam int F_COUNT_LSB = 0;    // Count value overlays bits 10:0
  localparam int F_TU = 11;          // time_unit_select
  localparam int F_CA = 12;          // counter_algorithm
  localparam int F_FWD_LSB = 13;     // Forward port mask
  localparam int ACT_FIXED_W = 13;   // Bits below the forward mask

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;      // Core clock rate
  localparam int US_NS = 1000;       // One microsecond in ns
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int US_CYCLES = US_NS / CLK_NS;  // Cycles per microsecond
  localparam int MS_PER_US = 1000;   // Microseconds per millisecond
endpackage : aac_pkg

/* File: tb/aac_asserts.sv */
/* Checker on the ports of the action and count engine.
   Assumes it is bound into aac_engine: one clock, synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module aac_asserts #(
  parameter int PORTS = 7,
  parameter int ENTRIES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [1:0] wr_match_mode_i,
  input wire logic [1:0] wr_match_select_i,
  input wire logic pkt_valid_i,
  input wire logic pkt_hit_i,
  input wire logic [3:0] pkt_idx_i,
  input wire logic [2:0] qos_pri_i,
  input wire logic [2:0] pcp_i,
  input wire logic [PORTS-1:0] lookup_map_i,
  input wire logic res_valid_o,
  input wire logic [2:0] res_pri_o,
  input wire logic [2:0] res_pcp_o,
  input wire logic [PORTS-1:0] res_map_o,
  input wire logic [31:0] res_process_o,
  input wire logic [ENTRIES-1:0] int_clear_i,
  input wire logic int_mask_i,
  input wire logic [ENTRIES-1:0] int_status_o,
  input wire logic port_int_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [ENTRIES-1:0] cnt_q; // Entries in count mode
  logic [ENTRIES-1:0] off_q; // Disabled entries
  // Mirror of the table kind, so refusals can be told apart
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      off_q <= '1;
    end else if (wr_en_i) begin
      cnt_q[wr_idx_i] <= wr_match_mode_i == 2'h1 && wr_match_select_i == 2'h0;
      off_q[wr_idx_i] <= wr_match_mode_i == 2'h0;
    end
  end
  // Result equals the untouched lookup side
  // z set: the process field must read zero as well
  property pass_p(c, z);
    c |=> res_map_o == $past(lookup_map_i) && res_pri_o == $past(qos_pri_i)
      && res_pcp_o == $past(pcp_i) && (!z || res_process_o == 32'h0);
  endproperty
  a_res_follows: assert property (pkt_valid_i |=> res_valid_o) else $error("result late");
  a_res_idle: assert property (!pkt_valid_i |=> !res_valid_o) else $error("stray result");
  a_miss_pass: assert property (pass_p(pkt_valid_i && !pkt_hit_i, 1'b1)) else $error("miss altered");
  a_off_pass: assert property (pass_p(pkt_valid_i && pkt_hit_i && off_q[pkt_idx_i], 1'b1))
    else $error("disabled entry acted");
  a_cnt_pass: assert property (pass_p(pkt_valid_i && pkt_hit_i && cnt_q[pkt_idx_i], 1'b0))
    else $error("count entry acted");
  a_port_int: assert property (port_int_o == (|int_status_o && !int_mask_i))
    else $error("port interrupt wrong");
  a_only_count: assert property ((int_status_o & ~$past(int_status_o)
    & ~(cnt_q | $past(cnt_q))) == '0) else $error("filter raised status");
  a_status_sticky: assert property (!$past(rst_i) |-> (~int_status_o
    & $past(int_status_o) & ~$past(int_clear_i)) == '0) else $error("status lost");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    int_status_o == '0 && !res_valid_o && !port_int_o) else $error("reset not quiet");
  c_hit_b2b: cover property (pkt_valid_i && pkt_hit_i ##1 pkt_valid_i);
  c_int_up: cover property ($rose(port_int_o));
  c_masked: cover property (|int_status_o && int_mask_i);
endmodule : aac_asserts
`default_nettype wire

/* File: tb/aac_pipe_model.sv */
/* Model of the match and lookup stage feeding packets to the engine.
   Assumes the bench hands it a fresh random word each cycle. */
`timescale 1ns/10ps
`default_nettype none
module aac_pipe_model #(
  parameter int PORTS = 7
) (
  input wire logic clk_i,
  input wire logic en_i, // Random traffic on
  input wire logic force_i, // Forced hit request
  input wire logic [3:0] force_idx_i,
  input wire logic [31:0] rnd_i,
  output logic pkt_valid_o,
  output logic pkt_hit_o,
  output logic [3:0] pkt_idx_o,
  output logic [2:0] qos_o,
  output logic [2:0] pcp_o,
  output logic [PORTS-1:0] map_o
);
  // Launch on the falling edge; idle fields keep changing, never stale
  always @(negedge clk_i) begin
    pkt_valid_o <= force_i || (en_i && rnd_i[31]);
    pkt_hit_o <= force_i || rnd_i[30:28] != 3'h0;
    pkt_idx_o <= force_i ? force_idx_i : rnd_i[3:0];
    qos_o <= rnd_i[6:4];
    pcp_o <= rnd_i[9:7];
    map_o <= rnd_i[10+:PORTS];
  end
endmodule : aac_pipe_model
`default_nettype wire

/* File: tb/tb_top.sv */
/* Self-checking bench for the action and count engine.
   Assumes the engine, its package, the checker and the feed model. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int PORTS = 7;
  logic clk_i, rst_i, wr_en_i, en, frc, int_mask_i, pkt_valid_i, pkt_hit_i;
  logic res_valid_o, port_int_o;
  logic [3:0] wr_idx_i, fidx, pkt_idx_i;
  logic [1:0] wr_match_mode_i, wr_match_select_i;
  logic [aac_pkg::ACT_FIXED_W+PORTS-1:0] wr_action_i;
  logic [31:0] wr_process_i, res_process_o;
  logic [31:0] rnd = 32'h3C48; // Random source
  logic [2:0] qos_pri_i, pcp_i, res_pri_o, res_pcp_o;
  logic [PORTS-1:0] lookup_map_i, res_map_o;
  logic [15:0] int_clear_i, int_status_o;
  int num_errors, checks, md[16], sl[16], ac[16], pr[16];
  logic [44:0] expq[$]; // Expected results in order
  aac_engine #(.PORTS(PORTS), .MS_UNITS(2)) dut (.clk_i, .rst_i, .wr_en_i, .wr_idx_i,
    .wr_match_mode_i, .wr_match_select_i, .wr_action_i, .wr_process_i, .pkt_valid_i,
    .pkt_hit_i, .pkt_idx_i, .qos_pri_i, .pcp_i, .lookup_map_i, .res_valid_o, .res_pri_o,
    .res_pcp_o, .res_map_o, .res_process_o, .int_clear_i, .int_mask_i, .int_status_o,
    .port_int_o);
  aac_pipe_model #(.PORTS(PORTS)) u_pipe (.clk_i, .en_i(en), .force_i(frc),
    .force_idx_i(fidx), .rnd_i(rnd), .pkt_valid_o(pkt_valid_i), .pkt_hit_o(pkt_hit_i),
    .pkt_idx_o(pkt_idx_i), .qos_o(qos_pri_i), .pcp_o(pcp_i), .map_o(lookup_map_i));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Reference result of one packet
  function automatic logic [44:0] exp_f(logic h, logic [3:0] i, logic [2:0] q, c,
      logic [6:0] m);
    int a;
    logic [2:0] p;
    a = ac[i];
    p = a[8:6];
    if (!h || md[i] == 0) return {q, c, m, 32'h0};
    if (md[i] == 1 && sl[i] == 0) return {q, c, m, 32'(pr[i])};
    if (a[10:9] == 0 || (a[10:9] == 1 && p <= q) || (a[10:9] == 2 && p >= q)) p = q;
    if (a[5]) c = a[4:2];
    if (a[1:0] == 1) m = m | a[19:13];
    if (a[1:0] == 2) m = m & a[19:13];
    if (a[1:0] == 3) m = a[19:13];
    return {p, c, m, pr[i]};
  endfunction : exp_f
  task automatic chk(string n, logic [44:0] s, logic [44:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Caller lowers the strobe after its last write
  task automatic wr(int i, int m, int s, int a, int p);
    {wr_en_i, wr_idx_i, wr_match_mode_i, wr_match_select_i} <= {1'b1, 4'(i), 2'(m), 2'(s)};
    {wr_action_i, wr_process_i} <= {a[19:0], 32'(p)};
    @(negedge clk_i);
    {md[i], sl[i], ac[i], pr[i]} = {m, s, a, p};
  endtask : wr
  task automatic hit(int i);
    frc <= 1'b1;
    fidx <= 4'(i);
    @(negedge clk_i);
    frc <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : hit
  // Countdown on entry 14, optional reload after pre cycles
  task automatic cd(logic tu, logic [10:0] n, int pre, int lim);
    int w;
    int_clear_i <= 16'h4000;
    wr(14, 1, 0, {8'h0, tu, n}, 0);
    {wr_en_i, int_clear_i} <= '0;
    hit(14);
    repeat (pre) @(negedge clk_i);
    if (pre > 0) hit(14);
    repeat (390) @(negedge clk_i);
    chk("timer early", int_status_o[14], 0);
    for (w = 0; w < lim && int_status_o[14] !== 1'b1; w++) @(negedge clk_i);
    chk("timer expiry", int_status_o[14], 1);
    if (w == lim) summarize();
  endtask : cd
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) rnd <= lfsr(rnd);
  // Queue the packet that the engine takes at this edge
  always @(posedge clk_i) begin
    if (pkt_valid_i === 1'b1 && !rst_i) expq.push_back(exp_f(pkt_hit_i, pkt_idx_i, qos_pri_i,
      pcp_i, lookup_map_i));
  end
  // Compare each result half a cycle after launch, once it has settled
  always @(negedge clk_i) begin
    if (res_valid_o === 1'b1) begin
      if (expq.size() == 0) chk("stray result", 1, 0);
      else chk("result", {res_pri_o, res_pcp_o, res_map_o, res_process_o}, expq.pop_front());
    end
  end
  initial begin
    {rst_i, wr_en_i, wr_idx_i, wr_match_mode_i, wr_match_select_i} = 10'h200;
    {wr_action_i, wr_process_i, en, frc, fidx, int_clear_i, int_mask_i} = '0;
    repeat (16) @(negedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++)
      wr(i, i == 12 ? 0 : 1 + rnd % 3, 1 + rnd[5:4] % 3, {rnd[19:11], i[1:0], rnd[8:2],
        i[3:2]}, rnd);
    wr(13, 1, 0, {8'hFF, 1'b0, 11'h003}, 0);
    wr_en_i <= 1'b0;
    for (int k = 1; k <= 6; k++) begin
      hit(13);
      chk("packet count", int_status_o[13], k % 3 == 0);
      int_clear_i <= k == 3 ? 16'h2000 : 16'h0;
    end
    int_mask_i <= 1'b1;
    @(negedge clk_i);
    chk("masked", port_int_o, 0);
    int_mask_i <= 1'b0;
    @(negedge clk_i);
    chk("unmasked", port_int_o, 1);
    cd(1'b0, 11'h003, 0, 230);
    cd(1'b1, 11'h002, 0, 430);
    cd(1'b0, 11'h003, 300, 230);
    chk("filter status", int_status_o & 16'h9FFF, 0);
    en <= 1'b1;
    repeat (600) @(negedge clk_i);
    en <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk("drained", expq.size(), 0);
    summarize();
  end
endmodule : tb_top
bind aac_engine aac_asserts #(.PORTS(PORTS), .ENTRIES(ENTRIES)) u_chk (.clk_i, .rst_i,
  .wr_en_i, .wr_idx_i, .wr_match_mode_i, .wr_match_select_i, .pkt_valid_i, .pkt_hit_i,
  .pkt_idx_i, .qos_pri_i, .pcp_i, .lookup_map_i, .res_valid_o, .res_pri_o, .res_pcp_o,
  .res_map_o, .res_process_o, .int_clear_i, .int_mask_i, .int_status_o, .port_int_o);
`default_nettype wire
